// [rtl/tsc_pkg.sv]
/*
 * Package for the timer section control block: register indices,
 * field positions, reset values, trigger and clock-select codes and
 * the rates used to derive count ticks.
 * Assumes a 125 MHz system clock and 32-bit APB register access.
 */
`default_nettype none

package tsc_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam int IDX_W = 6;
    localparam logic [5:0] IDX_RUN_STOP = 6'h0E;
    localparam logic [5:0] IDX_T0_CTRL = 6'h0F;
    localparam logic [5:0] IDX_RELOAD_HI = 6'h10;
    localparam logic [5:0] IDX_RELOAD_LO = 6'h11;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h20;
    localparam logic [5:0] IDX_COUNT = 6'h21;
    localparam int ADDR_W = 8;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int RS_MASK_LSB = 0;     // write mask, bits 3..0
    localparam int RS_ACTIVE_LSB = 4;   // running bits, bits 7..4
    localparam int NUM_TIMERS = 4;
    localparam int CT_HALT_RX = 7;
    localparam int CT_TRIG_LSB = 4;
    localparam int CT_RELOAD_ZERO = 3;
    localparam int CT_CLK_LSB = 0;
    localparam int ST_IRQ = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_RELOAD = 8'h00;
    localparam logic [3:0] RST_ACTIVE = 4'h0;
    localparam logic [15:0] RST_COUNT = 16'h0000;

    // ------------------------------------------------------------
    // start trigger and count clock codes
    // ------------------------------------------------------------
    localparam logic [1:0] TRIG_NONE = 2'h0;
    localparam logic [1:0] TRIG_TX_END = 2'h1;
    localparam logic [1:0] TRIG_TRIM_NO_UF = 2'h2;
    localparam logic [1:0] TRIG_TRIM_UF = 2'h3;
    localparam logic [1:0] CLK_CARRIER = 2'h0;
    localparam logic [1:0] CLK_SLOW = 2'h1;
    localparam logic [1:0] CLK_TIMER_TWO = 2'h2;
    localparam logic [1:0] CLK_TIMER_ONE = 2'h3;

    // ------------------------------------------------------------
    // tick rates
    // ------------------------------------------------------------
    localparam longint F_PCLK_HZ = 125_000_000;
    localparam longint F_CARRIER_HZ = 13_560_000;
    localparam longint F_SLOW_HZ = 211_875;
    localparam int SLOW_DIV = int'(F_CARRIER_HZ / F_SLOW_HZ);
    localparam int SLOW_W = $clog2(SLOW_DIV);
    localparam int ACC_W = 24;
    localparam logic [63:0] ACC_INC64 =
        64'((F_CARRIER_HZ << ACC_W) / F_PCLK_HZ);
    localparam logic [ACC_W-1:0] ACC_INC = ACC_INC64[ACC_W-1:0];

endpackage : tsc_pkg

`default_nettype wire

// [rtl/tsc_tick_if.sv]
/*
 * Interface carrying the count tick enables from the tick divider
 * to the timer logic.
 * Assumes both ends run on the same system clock.
 */
`default_nettype none

interface tsc_tick_if;
    logic carrier_tick;   // one pclk cycle per carrier period
    logic slow_tick;      // one pclk cycle per divided period

    modport src (output carrier_tick, output slow_tick);
    modport snk (input carrier_tick, input slow_tick);
endinterface : tsc_tick_if

`default_nettype wire

// [rtl/tsc_tick_gen.sv]
/*
 * Tick divider: a phase accumulator makes the carrier-rate enable
 * from pclk, and a counter divides it down to the slow rate.
 * Assumes pclk is well above the carrier rate.
 */
`default_nettype none

module tsc_tick_gen (
    input  wire logic pclk,
    input  wire logic presetn,
    tsc_tick_if.src   ticks
);

    logic [tsc_pkg::ACC_W-1:0]  acc;
    logic [tsc_pkg::SLOW_W-1:0] div;
    logic [tsc_pkg::ACC_W:0]    sum;

    // carry out of the accumulator marks a carrier period; jitter is
    // one pclk cycle, traded for no analogue clock in this domain
    assign sum = {1'b0, acc} + {1'b0, tsc_pkg::ACC_INC};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= '0;
            ticks.carrier_tick <= 1'b0;
        end else begin
            acc <= sum[tsc_pkg::ACC_W-1:0];
            ticks.carrier_tick <= sum[tsc_pkg::ACC_W];
        end
    end

    // slow tick every SLOW_DIV carrier ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div <= '0;
            ticks.slow_tick <= 1'b0;
        end else begin
            ticks.slow_tick <= 1'b0;
            if (ticks.carrier_tick) begin
                div <= div + 1'b1;
                if (div == tsc_pkg::SLOW_W'(tsc_pkg::SLOW_DIV - 1)) begin
                    div <= '0;
                    ticks.slow_tick <= 1'b1;
                end
            end
        end
    end

endmodule : tsc_tick_gen

`default_nettype wire

// [rtl/tsc_timer_ctrl.sv]
/*
 * Timer section control: masked run/stop register for four timers,
 * and the first timer's control, reload and down counter, reached
 * over an APB slave.
 * Assumes all event inputs are synchronous one-cycle pulses or
 * levels on pclk; the other three timers live outside this block.
 * Software keeps clear of the counter readout during reception.
 */
// Design decision made here: the APB interface to the registers.
`default_nettype none

module tsc_timer_ctrl (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [tsc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    // link to the transceiver and the other timers
    input  wire logic                      tx_end,
    input  wire logic                      rx_first_nibble,
    input  wire logic                      trim_reference,
    input  wire logic                      timer_one_underflow,
    input  wire logic                      timer_two_underflow,
    output logic [3:0]                     timer_active,
    output logic                           timer_zero_underflow,
    output logic                           timer_underflow_irq_flag
);

    // ------------------------------------------------------------
    // tick divider
    // ------------------------------------------------------------
    // one accumulator feeds both rates, so they never drift apart
    tsc_tick_if ticks ();

    tsc_tick_gen u_tick_gen (
        .pclk    (pclk),
        .presetn (presetn),
        .ticks   (ticks)
    );

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic                     halt_on_receive;
    logic [1:0]               start_trigger_select;
    logic                     reload_on_zero;
    logic [1:0]               count_clock_select;
    logic [7:0]               reload_value_high;
    logic [7:0]               reload_value_low;
    logic [15:0]              reload_value;
    logic [15:0]              count;
    logic                     ref_q;
    logic [3:1]               outer_active;
    logic                     zero_active;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic [tsc_pkg::IDX_W-1:0] idx;
    logic                      wr;
    logic                      setup;
    logic                      rs_wr;
    logic [3:0]                wmask;
    logic [3:0]                wval;

    // every register is one aligned word; paddr[1:0] are ignored
    assign idx = paddr[tsc_pkg::ADDR_W-1:2];
    // writes land at the access edge; low lane carries all fields
    assign wr = psel & penable & pwrite & pstrb[0];
    assign setup = psel & ~penable;
    assign rs_wr = wr & (idx == tsc_pkg::IDX_RUN_STOP);
    assign wmask = pwdata[tsc_pkg::RS_MASK_LSB +: 4];
    assign wval = pwdata[tsc_pkg::RS_ACTIVE_LSB +: 4];

    // read data is captured in setup, so no wait state is needed
    assign pready = 1'b1;

    // ------------------------------------------------------------
    // timer zero events
    // ------------------------------------------------------------
    logic trim_mode;
    logic trim_edge;
    logic sw_start;
    logic sw_stop;
    logic auto_start;
    logic auto_stop;
    logic tick;
    logic at_zero;
    logic uf;
    logic override;

    assign trim_mode = start_trigger_select[1];
    // ref_q resets to the idle low level, so reset makes no false edge
    assign trim_edge = trim_reference & ~ref_q;
    // masked software start and stop of timer zero
    assign sw_start = rs_wr & wmask[0] & wval[0];
    assign sw_stop = rs_wr & wmask[0] & ~wval[0];

    // automatic starts; trigger zero offers none
    always_comb begin
        auto_start = 1'b0;
        case (start_trigger_select)
            tsc_pkg::TRIG_NONE: auto_start = 1'b0;
            tsc_pkg::TRIG_TX_END: auto_start = tx_end;
            tsc_pkg::TRIG_TRIM_NO_UF,
            tsc_pkg::TRIG_TRIM_UF:
                auto_start = trim_edge & ~timer_active[0];
            default: auto_start = 1'b0;
        endcase
    end

    // reference edge stops a trimming run; receive halt needs the
    // trimming modes off, else the measurement would be cut short
    assign auto_stop = (trim_mode & trim_edge & timer_active[0])
        | (halt_on_receive & ~trim_mode & rx_first_nibble);

    // count tick selection
    // cascade inputs are one-cycle underflow pulses of the neighbours
    always_comb begin
        tick = 1'b0;
        case (count_clock_select)
            tsc_pkg::CLK_CARRIER: tick = ticks.carrier_tick;
            tsc_pkg::CLK_SLOW: tick = ticks.slow_tick;
            tsc_pkg::CLK_TIMER_TWO: tick = timer_two_underflow;
            tsc_pkg::CLK_TIMER_ONE: tick = timer_one_underflow;
            default: tick = 1'b0;
        endcase
    end

    // a tick while at zero is the underflow, not the step to zero
    assign at_zero = (count == 16'h0000);
    assign reload_value = {reload_value_high, reload_value_low};

    // a start or stop on the same edge owns the counter, so the tick
    // is dropped and no underflow is flagged for it
    assign override = sw_stop | sw_start | auto_stop | auto_start;

    // trimming without underflow parks at zero and raises nothing
    assign uf = timer_active[0] & tick & at_zero & ~override
        & (start_trigger_select != tsc_pkg::TRIG_TRIM_NO_UF);

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    // reserved bits 6 and 2 are not stored and always read as zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_on_receive <= tsc_pkg::RST_CTRL[tsc_pkg::CT_HALT_RX];
            start_trigger_select <=
                tsc_pkg::RST_CTRL[tsc_pkg::CT_TRIG_LSB +: 2];
            reload_on_zero <= tsc_pkg::RST_CTRL[tsc_pkg::CT_RELOAD_ZERO];
            count_clock_select <=
                tsc_pkg::RST_CTRL[tsc_pkg::CT_CLK_LSB +: 2];
        end else if (wr && idx == tsc_pkg::IDX_T0_CTRL) begin
            halt_on_receive <= pwdata[tsc_pkg::CT_HALT_RX];
            start_trigger_select <= pwdata[tsc_pkg::CT_TRIG_LSB +: 2];
            reload_on_zero <= pwdata[tsc_pkg::CT_RELOAD_ZERO];
            count_clock_select <= pwdata[tsc_pkg::CT_CLK_LSB +: 2];
        end
    end

    // ------------------------------------------------------------
    // reload registers
    // ------------------------------------------------------------
    // only stored here; the counter picks them up at a start event and at an underflow with reload-on-zero set
    // the low byte lives at the index just above the high byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_value_high <= tsc_pkg::RST_RELOAD;
            reload_value_low <= tsc_pkg::RST_RELOAD;
        end else if (wr) begin
            if (idx == tsc_pkg::IDX_RELOAD_HI) begin
                reload_value_high <= pwdata[7:0];
            end
            if (idx == tsc_pkg::IDX_RELOAD_LO) begin
                reload_value_low <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // trimming reference edge detect
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_q <= 1'b0;
        end else begin
            ref_q <= trim_reference;
        end
    end

    // ------------------------------------------------------------
    // running bits of the outer timers
    // ------------------------------------------------------------
    // each bit moves only under its own mask bit
    genvar g;
    generate
        for (g = 1; g < tsc_pkg::NUM_TIMERS; g++) begin : g_outer
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    outer_active[g] <= tsc_pkg::RST_ACTIVE[g];
                end else if (rs_wr && wmask[g]) begin
                    outer_active[g] <= wval[g];
                end
            end
        end
    endgenerate

    // status bus: timer three in the top bit down to timer zero
    assign timer_active = {outer_active, zero_active};

    // ------------------------------------------------------------
    // timer zero counter
    // ------------------------------------------------------------
    // software outranks hardware events in the same cycle; a start
    // always reloads, so a running restart begins afresh
    // with reload-on-zero clear the count stays at zero when it stops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zero_active <= tsc_pkg::RST_ACTIVE[0];
            count <= tsc_pkg::RST_COUNT;
        end else if (sw_stop) begin
            zero_active <= 1'b0;
        end else if (sw_start) begin
            zero_active <= 1'b1;
            count <= reload_value;
        end else if (auto_stop) begin
            zero_active <= 1'b0;
        end else if (auto_start) begin
            zero_active <= 1'b1;
            count <= reload_value;
        end else if (timer_active[0] && tick) begin
            if (!at_zero) begin
                count <= count - 16'h0001;
            end else if (!uf) begin
                count <= count;
            end else if (reload_on_zero) begin
                count <= reload_value;
            end else begin
                zero_active <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // underflow pulse and interrupt request flag
    // ------------------------------------------------------------
    // the pulse is registered and rises on the same edge as the wrap; cascaded timers see it then
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_zero_underflow <= 1'b0;
        end else begin
            timer_zero_underflow <= uf;
        end
    end

    // set wins over a write-one-to-clear in the same cycle
    // so an underflow that races a clear is never lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_underflow_irq_flag <= 1'b0;
        end else if (uf) begin
            timer_underflow_irq_flag <= 1'b1;
        end else if (wr && idx == tsc_pkg::IDX_IRQ_STATUS
                     && pwdata[tsc_pkg::ST_IRQ]) begin
            timer_underflow_irq_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read data and error answer
    // ------------------------------------------------------------
    // the counter readout is a live snapshot; during reception it
    // may be mid-update from the receiver's view
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            // unmapped indices answer with an error and zero data
            case (idx)
                tsc_pkg::IDX_RUN_STOP:
                    prdata[7:0] <= {timer_active, 4'h0};
                tsc_pkg::IDX_T0_CTRL:
                    prdata[7:0] <= {halt_on_receive, 1'b0,
                                    start_trigger_select,
                                    reload_on_zero, 1'b0,
                                    count_clock_select};
                tsc_pkg::IDX_RELOAD_HI:
                    prdata[7:0] <= reload_value_high;
                tsc_pkg::IDX_RELOAD_LO:
                    prdata[7:0] <= reload_value_low;
                tsc_pkg::IDX_IRQ_STATUS:
                    prdata[tsc_pkg::ST_IRQ] <= timer_underflow_irq_flag;
                tsc_pkg::IDX_COUNT:
                    prdata[15:0] <= count;
                default:
                    pslverr <= 1'b1;
            endcase
        end
    end

endmodule : tsc_timer_ctrl

`default_nettype wire

// [verification/tsc_timer_ctrl_assertions.sv]
/*
 * Properties of tsc_timer_ctrl seen at its ports.
 * Assumes one pclk domain; bound onto every instance of the top.
 */
`default_nettype none

module tsc_checker (
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [tsc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                pwdata,
    input wire logic [3:0]                 pstrb,
    input wire logic                       tx_end,
    input wire logic                       rx_first_nibble,
    input wire logic                       trim_reference,
    input wire logic [3:0]                 timer_active,
    input wire logic                       timer_zero_underflow,
    input wire logic                       timer_underflow_irq_flag
);
    // ----------
    // helper logic
    // ----------
    logic       acc;
    logic       wr_rs;
    logic       wr0;
    logic [2:0] exp_outer;
    logic [7:0] ctrl;

    // accepted writes only: a low pstrb[0] is dropped by the design
    assign acc = psel && penable && pwrite && pstrb[0];
    assign wr_rs = acc && paddr[7:2] == tsc_pkg::IDX_RUN_STOP;
    assign wr0 = wr_rs && pwdata[0];
    assign exp_outer = (pwdata[7:5] & pwdata[3:1])
        | (timer_active[3:1] & ~pwdata[3:1]);

    // control copy, so that automatic events can be qualified
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= 8'h00;
        end else if (acc && paddr[7:2] == tsc_pkg::IDX_T0_CTRL) begin
            ctrl <= pwdata[7:0];
        end
    end

    // ----------
    // properties
    // ----------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_halt;
        rx_first_nibble && ctrl[7] && !ctrl[5] && !wr0;
    endsequence
    // the edge detector may still hold a recent reference edge
    sequence s_quiet;
        trim_reference == $past(trim_reference)
            && trim_reference == $past(trim_reference, 2);
    endsequence

    AST_OUTER_MASK: assert property (
        wr_rs |=> timer_active[3:1] == $past(exp_outer))
        else $error("masked write gave wrong outer bits");
    AST_ZERO_SW: assert property (
        wr0 |=> timer_active[0] == $past(pwdata[4]))
        else $error("timer zero ignored masked write");
    AST_HALT_RX: assert property (
        s_halt |=> !timer_active[0])
        else $error("timer zero ran on after first nibble");
    AST_HALT_TRIM: assert property (
        (timer_active[0] && rx_first_nibble && ctrl[5:4] == 2'h2 && !wr0
        ##0 s_quiet) |=> timer_active[0])
        else $error("receive halt acted in trimming mode");
    AST_NO_AUTO: assert property (
        !timer_active[0] && ctrl[5:4] == tsc_pkg::TRIG_NONE && !wr0
        |=> !timer_active[0])
        else $error("timer zero started by itself");
    AST_TX_START: assert property (
        tx_end && ctrl[5:4] == tsc_pkg::TRIG_TX_END && !wr0
        && !(rx_first_nibble && ctrl[7]) |=> timer_active[0])
        else $error("transmit end did not start timer zero");
    AST_UF_IRQ: assert property (
        timer_zero_underflow |-> timer_underflow_irq_flag)
        else $error("underflow without interrupt flag");
    AST_UF_RELOAD: assert property (
        timer_zero_underflow |-> timer_active[0] == ctrl[3])
        else $error("running state after underflow wrong");
endmodule : tsc_checker

bind tsc_timer_ctrl tsc_checker tsc_checker_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .tx_end, .rx_first_nibble, .trim_reference, .timer_active,
    .timer_zero_underflow, .timer_underflow_irq_flag
);

`default_nettype wire

// [verification/timer_section_control_test.sv]
/*
 * Bench for tsc_timer_ctrl: apb tasks and directed register tests.
 * Assumes the zero-wait slave; cascade ticks are driven here.
 */
`default_nettype none

module timer_section_control_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------
    // addresses and signals
    // ----------
    localparam logic [7:0] RS = {tsc_pkg::IDX_RUN_STOP, 2'h0};
    localparam logic [7:0] CT = {tsc_pkg::IDX_T0_CTRL, 2'h0};
    localparam logic [7:0] RH = {tsc_pkg::IDX_RELOAD_HI, 2'h0};
    localparam logic [7:0] RL = {tsc_pkg::IDX_RELOAD_LO, 2'h0};
    localparam logic [7:0] IS = {tsc_pkg::IDX_IRQ_STATUS, 2'h0};
    localparam logic [7:0] CN = {tsc_pkg::IDX_COUNT, 2'h0};
    localparam logic [7:0] MW [6] =
        '{8'hF0, 8'hFF, 8'hA5, 8'h0F, 8'h33, 8'h0F};
    localparam logic [7:0] MR [6] =
        '{8'h00, 8'hF0, 8'hA0, 8'h00, 8'h30, 8'h00};
    logic                       pclk, presetn, psel, penable, pwrite;
    logic [tsc_pkg::ADDR_W-1:0] paddr;
    logic [31:0]                pwdata, prdata, q0, q1;
    logic [3:0]                 pstrb, timer_active;
    logic [3:0]                 ev;  // tx end, nibble, timer 1, timer 2
    logic                       pready, pslverr, trim, uf, irq, serr;
    int                         errors, check_count;

    tsc_timer_ctrl tsc_timer_ctrl_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr,
        .tx_end(ev[0]), .rx_first_nibble(ev[1]), .trim_reference(trim),
        .timer_one_underflow(ev[2]), .timer_two_underflow(ev[3]),
        .timer_active, .timer_zero_underflow(uf),
        .timer_underflow_irq_flag(irq)
    );

    // free-running 125 MHz clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // ----------
    // tasks
    // ----------
    task summarize();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    task chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("FAIL %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk

    task chk1(input logic s, input logic e);
        chk({31'h0, s}, {31'h0, e});
    endtask : chk1

    // one transfer; the wait on pready is bounded, never open-ended
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            errors++;
            summarize();
        end
        q = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb

    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h000000, d}, q0);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000, q0);
        chk(q0, e);
    endtask : rd

    // one-cycle event pulses, one idle cycle apart
    task pulse(input int k, input int times);
        repeat (times) begin
            @(posedge pclk);
            ev[k] <= 1'b1;
            @(posedge pclk);
            ev[k] <= 1'b0;
        end
        #1;
    endtask : pulse

    // slow rising edge so the one-register detector surely sees it
    task trim_edge();
        @(posedge pclk);
        trim <= 1'b1;
        repeat (3) @(posedge pclk);
        trim <= 1'b0;
        repeat (3) @(posedge pclk);
        #1;
    endtask : trim_edge

    // samples lie span+3 edges apart; divider phase is unknown
    task rate(input logic [7:0] c, input int span, input int lo,
              input int hi);
        wr(CT, c);
        wr(RS, 8'h11);
        apb(1'b0, CN, 32'h00000000, q1);
        repeat (span) @(posedge pclk);
        apb(1'b0, CN, 32'h00000000, q0);
        chk1((q1 - q0) inside {[lo:hi]}, 1'b1);
    endtask : rate

    // ----------
    // main sequence
    // ----------
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, trim} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        pstrb = 4'hF;
        ev = 4'h0;
        errors = 0;
        check_count = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(RS, 32'h00000000);
        rd(8'h00, 32'h00000000);
        chk1(serr, 1'b1);
        $display("test done: reset and map");
        wr(CT, 8'h02);
        foreach (MW[i]) begin
            wr(RS, MW[i]);
            chk({28'h0, timer_active}, {28'h0, MR[i][7:4]});
            rd(RS, {24'h000000, MR[i]});
        end
        $display("test done: run/stop mask");
        wr(RL, 8'h03);
        wr(RS, 8'h11);
        rd(CN, 32'h00000003);
        pulse(3, 1);
        rd(CN, 32'h00000002);
        pulse(2, 1);
        rd(CN, 32'h00000002);
        wr(RH, 8'h12);
        pulse(3, 2);
        rd(CN, 32'h00000000);
        pulse(3, 1);
        chk1(uf, 1'b1);
        chk1(timer_active[0], 1'b0);
        rd(IS, 32'h00000001);
        chk1(irq, 1'b1);
        pulse(3, 1);
        rd(CN, 32'h00000000);
        wr(RS, 8'h11);
        rd(CN, 32'h00001203);
        wr(CT, 8'h03);
        pulse(2, 1);
        rd(CN, 32'h00001202);
        wr(RS, 8'h01);
        wr(IS, 8'h01);
        rd(IS, 32'h00000000);
        chk1(irq, 1'b0);
        $display("test done: reload and cascade");
        wr(CT, 8'h0A);
        wr(RH, 8'h00);
        wr(RL, 8'h01);
        wr(RS, 8'h11);
        pulse(3, 2);
        chk1(timer_active[0], 1'b1);
        rd(CN, 32'h00000001);
        wr(IS, 8'h01);
        wr(RS, 8'h01);
        $display("test done: auto restart");
        wr(CT, 8'h02);
        pulse(0, 1);
        chk1(timer_active[0], 1'b0);
        wr(CT, 8'h12);
        pulse(0, 1);
        chk1(timer_active[0], 1'b1);
        wr(CT, 8'h92);
        pulse(1, 1);
        chk1(timer_active[0], 1'b0);
        wr(CT, 8'h12);
        pulse(0, 1);
        pulse(1, 1);
        chk1(timer_active[0], 1'b1);
        wr(CT, 8'hA2);
        pulse(1, 1);
        chk1(timer_active[0], 1'b1);
        trim_edge();
        chk1(timer_active[0], 1'b0);
        trim_edge();
        rd(CN, 32'h00000001);
        pulse(3, 2);
        chk1(timer_active[0], 1'b1);
        rd(IS, 32'h00000000);
        wr(CT, 8'h32);
        trim_edge();
        trim_edge();
        pulse(3, 2);
        chk1(timer_active[0], 1'b0);
        rd(IS, 32'h00000001);
        $display("test done: triggers and halt");
        wr(RH, 8'hFF);
        rate(8'h00, 90, 10, 11);
        rate(8'h01, 1300, 2, 3);
        $display("test done: tick rates");
        summarize();
    end
endmodule : timer_section_control_test

`default_nettype wire
